// [pllc_edge_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface pllc_edge_if;
   import pllc_pkg::*;
   logic [N_W-1:0] n_eff;
   logic           run;
   logic           vco_edge;
   logic           ref_edge;
   logic           fb_edge;
   logic           fb_clk;
   modport div (input n_eff, input run, output vco_edge, output ref_edge,
                output fb_edge, output fb_clk);
   modport ctl (output n_eff, output run, input vco_edge, input ref_edge,
                input fb_edge, input fb_clk);
endinterface : pllc_edge_if
`default_nettype wire

// [pllc_fbdiv.sv]
`timescale 1ns/10ps
`default_nettype none
module pllc_fbdiv (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic srst,
   // Sampled clocks
   input  wire logic vco_output_clock,
   input  wire logic reference_clock,
   // Link to the control logic
   pllc_edge_if.div  eif
);
   import pllc_pkg::*;

   logic           vco_q_reg;
   logic           ref_q_reg;
   logic [N_W-1:0] cnt_reg;
   logic [N_W-1:0] cnt_next;
   logic           vco_rise;

   assign vco_rise = vco_output_clock & ~vco_q_reg;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (srst) begin
         vco_q_reg     <= 1'b0;
         ref_q_reg     <= 1'b0;
         eif.vco_edge  <= 1'b0;
         eif.ref_edge  <= 1'b0;
      end else begin
         vco_q_reg     <= vco_output_clock;
         ref_q_reg     <= reference_clock;
         eif.vco_edge  <= vco_rise;
         eif.ref_edge  <= reference_clock & ~ref_q_reg;
      end
   end

   // Down counter reloads with N-1, so one feedback edge per N VCO edges.
   always_comb begin
      cnt_next = cnt_reg;
      if (vco_rise) begin
         if (cnt_reg == '0) begin
            cnt_next = eif.n_eff - 1'b1;
         end else begin
            cnt_next = cnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || !eif.run) begin
         cnt_reg     <= '0;
         eif.fb_edge <= 1'b0;
         eif.fb_clk  <= 1'b0;
      end else begin
         cnt_reg     <= cnt_next;
         eif.fb_edge <= vco_rise && (cnt_reg == '0);
         eif.fb_clk  <= (cnt_next < (eif.n_eff >> 1)) || (eif.n_eff == 1);
      end
   end
endmodule : pllc_fbdiv
`default_nettype wire

// [pllc_pkg.sv]
package pllc_pkg;
   // Widths of the programming fields.
   localparam int N_W = 12;
   localparam int L_W = 8;
   localparam int E_W = 2;
   // Nominal VCO centre frequency in units of 100 Hz (71.4 kHz).
   localparam int unsigned FNOM_100HZ = 714;
   localparam int CTR_W = 20;
   localparam logic [CTR_W-1:0] FNOM_CNT = 20'h002ca;
   // Lock detector window in reference edges, tolerances in feedback edges.
   localparam int WIN_W = 8;
   localparam logic [WIN_W-1:0] LOCK_WIN_REFS = 8'h10;
   localparam logic [WIN_W-1:0] ACQ_TOL = 8'h02;
   localparam logic [WIN_W-1:0] LOCK_TOL = 8'h01;
   // Selected clock to bus clock ratio is four: base is /2, bus is /4.
   localparam int BUS_DIV = 4;
   localparam int BDIV_W = $clog2(BUS_DIV);
   // Reset values.
   localparam logic RST_NARROW = 1'b0;
   localparam logic RST_LOCK = 1'b0;
   localparam logic RST_IRQ = 1'b0;
   typedef enum logic [1:0] {
      PLLC_OFF   = 2'b00,
      PLLC_ACQ   = 2'b01,
      PLLC_TRACK = 2'b10
   } pllc_mode_t;
endpackage : pllc_pkg

// [pllc_top.sv]
// Behaviour
// - Feedback divider divides VCO clock by N; for N of one the feedback clock output stays high.
// - Phase detector emits up/down correction pulses.
// - Frequency compare sets filter mode and lock.
// - Narrow select reads zero during acquisition.
// - Tracking whenever the loop runs and narrow select is one.
// - Auto mode switches filter mode itself.
// - Auto mode ignores software narrow writes.
// - Auto narrow select follows tolerance window.
// - Auto lock flag follows tolerance window.
// - Enabled interrupt on every lock toggle made in auto mode.
// - Manual mode: narrow select is software control.
// - Manual mode: lock flag off, no interrupts.
// - Bus clock is quarter of selected clock.
// - Centre frequency is L*2^E*71.4 kHz, modulo 2^20 units of 100 Hz.
// - Multiplier zero behaves as one.
// - Factor L zero disables loop and VCO select.
`timescale 1ns/10ps
`default_nettype none
module pllc_top (
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     srst,
   // Clocks sampled as levels
   input  wire logic                     vco_output_clock,
   input  wire logic                     reference_clock,
   // Software control
   input  wire logic                     pll_power_on,
   input  wire logic                     base_clock_select,
   input  wire logic                     auto_bandwidth,
   input  wire logic                     filter_narrow_ctl,
   input  wire logic                     pll_irq_enable,
   input  wire logic                     irq_ack,
   input  wire logic [pllc_pkg::N_W-1:0] mult_n,
   input  wire logic [pllc_pkg::L_W-1:0] range_l,
   input  wire logic [pllc_pkg::E_W-1:0] range_e,
   // Loop outputs
   output logic                          vco_feedback_clock,
   output logic                          pump_up,
   output logic                          pump_down,
   output logic                          tracking_mode,
   output logic                          loop_enable,
   // Status
   output logic                          filter_narrow_sel,
   output logic                          lock_flag,
   output logic                          pll_irq,
   output pllc_pkg::pllc_mode_t          filter_mode,
   output logic [pllc_pkg::CTR_W-1:0]    vco_center_100hz,
   // Clocks out
   output logic                          vco_selected,
   output logic                          base_clock_output,
   output logic                          bus_clock
);
   import pllc_pkg::*;

   pllc_edge_if eif ();

   logic             run;
   logic [WIN_W-1:0] win_reg;
   logic [WIN_W-1:0] fb_cnt_reg;
   logic [WIN_W-1:0] diff;
   logic             win_end;
   logic             in_acq_tol;
   logic             in_lock_tol;
   logic             lock_next;
   logic [BDIV_W-1:0] bdiv_reg;
   logic [BDIV_W-1:0] bdiv_next;
   logic             sel_edge;

   function automatic logic [WIN_W-1:0] absdiff(input logic [WIN_W-1:0] a,
                                                input logic [WIN_W-1:0] b);
      absdiff = (a > b) ? (a - b) : (b - a);
   endfunction : absdiff

   ////////////////////////////////////////////////////////////////////////
   // A zero L would put the centre at zero, so the loop stays off.
   assign run = pll_power_on && (range_l != '0);
   assign eif.run = run;
   assign eif.n_eff = (mult_n == '0) ? N_W'(1) : mult_n;

   pllc_fbdiv u_fbdiv (
      .mclk             (mclk),
      .srst             (srst),
      .vco_output_clock (vco_output_clock),
      .reference_clock  (reference_clock),
      .eif              (eif)
   );

   always_ff @(posedge mclk) begin
      if (srst) begin
         vco_feedback_clock <= 1'b0;
         loop_enable        <= 1'b0;
         vco_center_100hz   <= '0;
      end else begin
         vco_feedback_clock <= eif.fb_clk;
         loop_enable        <= run;
         vco_center_100hz   <= CTR_W'((FNOM_CNT * range_l) << range_e);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Up starts on a reference edge, down on a feedback edge; once both
   // have been seen they cancel, leaving a pulse as wide as the skew.
   always_ff @(posedge mclk) begin
      if (srst || !run) begin
         pump_up   <= 1'b0;
         pump_down <= 1'b0;
      end else if ((pump_up || eif.ref_edge) && (pump_down || eif.fb_edge)) begin
         pump_up   <= 1'b0;
         pump_down <= 1'b0;
      end else begin
         pump_up   <= pump_up | eif.ref_edge;
         pump_down <= pump_down | eif.fb_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency comparison: feedback edges counted over a window of
   // reference edges. Resolution is one edge per window, so a slow
   // reference makes the detector slow too.
   assign win_end = eif.ref_edge && (win_reg == LOCK_WIN_REFS - 1'b1);
   assign diff = absdiff(fb_cnt_reg + WIN_W'(eif.fb_edge), LOCK_WIN_REFS);
   assign in_acq_tol = diff <= ACQ_TOL;
   assign in_lock_tol = diff <= LOCK_TOL;

   always_ff @(posedge mclk) begin
      if (srst || !run) begin
         win_reg    <= '0;
         fb_cnt_reg <= '0;
      end else if (win_end) begin
         win_reg    <= '0;
         fb_cnt_reg <= '0;
      end else begin
         if (eif.ref_edge) begin
            win_reg <= win_reg + 1'b1;
         end
         if (eif.fb_edge && fb_cnt_reg != '1) begin
            fb_cnt_reg <= fb_cnt_reg + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (srst) begin
         filter_narrow_sel <= RST_NARROW;
      end else if (!auto_bandwidth) begin
         filter_narrow_sel <= filter_narrow_ctl;
      end else if (!run) begin
         filter_narrow_sel <= 1'b0;
      end else if (win_end) begin
         filter_narrow_sel <= in_acq_tol;
      end
   end

   assign lock_next = !auto_bandwidth ? 1'b0 :
                      !run ? 1'b0 :
                      win_end ? in_lock_tol : lock_flag;

   always_ff @(posedge mclk) begin
      if (srst) begin
         lock_flag <= RST_LOCK;
      end else begin
         lock_flag <= lock_next;
      end
   end

   // A new toggle in the acknowledge cycle keeps the request standing.
   always_ff @(posedge mclk) begin
      if (srst) begin
         pll_irq <= RST_IRQ;
      end else begin
         pll_irq <= (pll_irq && !irq_ack) ||
                    (pll_irq_enable && auto_bandwidth &&
                     (lock_next != lock_flag));
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         tracking_mode <= 1'b0;
         filter_mode   <= PLLC_OFF;
      end else begin
         tracking_mode <= run && filter_narrow_sel;
         if (!run) begin
            filter_mode <= PLLC_OFF;
         end else if (filter_narrow_sel) begin
            filter_mode <= PLLC_TRACK;
         end else begin
            filter_mode <= PLLC_ACQ;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock source select without the glitch-free transition logic; the
   // counter keeps running across a switch, so one period may be short.
   assign sel_edge = vco_selected ? eif.vco_edge : eif.ref_edge;
   assign bdiv_next = bdiv_reg + BDIV_W'(sel_edge);

   always_ff @(posedge mclk) begin
      if (srst) begin
         vco_selected      <= 1'b0;
         bdiv_reg          <= '0;
         base_clock_output <= 1'b0;
         bus_clock         <= 1'b0;
      end else begin
         vco_selected      <= base_clock_select && run;
         bdiv_reg          <= bdiv_next;
         base_clock_output <= bdiv_next[0];
         bus_clock         <= bdiv_next[BDIV_W-1];
      end
   end
endmodule : pllc_top
`default_nettype wire

// [pllc_top_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module pllc_chk
   import pllc_pkg::*;
(
   // Clock and reset
   input wire logic             mclk,
   input wire logic             srst,
   // Controls
   input wire logic             auto_bandwidth,
   input wire logic             filter_narrow_ctl,
   input wire logic             pll_irq_enable,
   input wire logic             irq_ack,
   input wire logic [L_W-1:0]   range_l,
   // Status
   input wire logic             loop_enable,
   input wire logic             vco_selected,
   input wire logic             filter_narrow_sel,
   input wire logic             lock_flag,
   input wire logic             pll_irq,
   input wire pllc_mode_t       filter_mode,
   // Phase detector
   input wire logic             pump_up,
   input wire logic             pump_down
);
   logic [1:0] rst_hist;
   // A reset raised on a clock edge reaches the flops one edge late, so the
   // properties stay off for two more edges after it falls.
   always_ff @(posedge mclk) begin
      rst_hist <= {rst_hist[0], srst};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst || rst_hist != 2'b00);
   ////////////////////////////////////////////////////////////////////////
   sequence s_lock_moves;
      $changed(lock_flag) && $past(auto_bandwidth && pll_irq_enable);
   endsequence
   property p_irq_set; s_lock_moves |-> pll_irq; endproperty
   property p_irq_hold; pll_irq && !irq_ack |=> pll_irq; endproperty
   property p_loop_off; range_l == 8'h00 |=> !loop_enable; endproperty
   property p_vco_block; (range_l == 8'h00)[*3] |=> !vco_selected;
   endproperty
   property p_man_narrow;
      !auto_bandwidth |=> filter_narrow_sel == $past(filter_narrow_ctl);
   endproperty
   property p_man_lock; !auto_bandwidth |=> !lock_flag; endproperty
   property p_man_irq; !auto_bandwidth && !pll_irq |=> !pll_irq; endproperty
   property p_acq_zero;
      filter_mode == PLLC_ACQ |-> !$past(filter_narrow_sel);
   endproperty
   property p_pump_excl; !(pump_up && pump_down); endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq missing");
   a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
   a_loop_off: assert property (p_loop_off) else $error("loop on");
   a_vco_block: assert property (p_vco_block) else $error("vco sel");
   a_man_narrow: assert property (p_man_narrow) else $error("narrow");
   a_man_lock: assert property (p_man_lock) else $error("lock on");
   a_man_irq: assert property (p_man_irq) else $error("manual irq");
   a_acq_zero: assert property (p_acq_zero) else $error("acq narrow");
   a_pump_excl: assert property (p_pump_excl) else $error("pumps");
endmodule : pllc_chk
bind pllc_top pllc_chk u_pllc_chk (.mclk(mclk), .srst(srst),
   .auto_bandwidth(auto_bandwidth), .filter_narrow_ctl(filter_narrow_ctl),
   .pll_irq_enable(pll_irq_enable), .irq_ack(irq_ack), .range_l(range_l),
   .loop_enable(loop_enable), .vco_selected(vco_selected),
   .filter_narrow_sel(filter_narrow_sel), .lock_flag(lock_flag),
   .pll_irq(pll_irq), .filter_mode(filter_mode),
   .pump_up(pump_up), .pump_down(pump_down));
`default_nettype wire

// [pllc_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pllc_top_tb;
   import pllc_pkg::*;
   logic mclk, srst, vco_output_clock, reference_clock, pll_power_on;
   logic base_clock_select, auto_bandwidth, filter_narrow_ctl;
   logic pll_irq_enable, irq_ack, vco_feedback_clock, pump_up, pump_down;
   logic tracking_mode, loop_enable, filter_narrow_sel, lock_flag, pll_irq;
   logic vco_selected, base_clock_output, bus_clock;
   logic [N_W-1:0] mult_n;
   logic [L_W-1:0] range_l;
   logic [E_W-1:0] range_e;
   logic [CTR_W-1:0] vco_center_100hz;
   pllc_mode_t filter_mode;
   int cyc, vp, vph, fails, check_count, p, i, cu, cd;
   pllc_top u_pllc_top (
      .mclk              (mclk),
      .srst              (srst),
      .vco_output_clock  (vco_output_clock),
      .reference_clock   (reference_clock),
      .pll_power_on      (pll_power_on),
      .base_clock_select (base_clock_select),
      .auto_bandwidth    (auto_bandwidth),
      .filter_narrow_ctl (filter_narrow_ctl),
      .pll_irq_enable    (pll_irq_enable),
      .irq_ack           (irq_ack),
      .mult_n            (mult_n),
      .range_l           (range_l),
      .range_e           (range_e),
      .vco_feedback_clock(vco_feedback_clock),
      .pump_up           (pump_up),
      .pump_down         (pump_down),
      .tracking_mode     (tracking_mode),
      .loop_enable       (loop_enable),
      .filter_narrow_sel (filter_narrow_sel),
      .lock_flag         (lock_flag),
      .pll_irq           (pll_irq),
      .filter_mode       (filter_mode),
      .vco_center_100hz  (vco_center_100hz),
      .vco_selected      (vco_selected),
      .base_clock_output (base_clock_output),
      .bus_clock         (bus_clock)
   );
   always #4 mclk = ~mclk;
   // Both clocks are sampled levels, so they are stepped on mclk edges.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      reference_clock <= (cyc % 8) < 4;
      vco_output_clock <= ((cyc + vph) % vp) < vp / 2;
      if (auto_bandwidth) filter_narrow_ctl <= 1'($urandom);
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s exp %0h got %0h", nm, e, s);
      end
   endtask : chk
   task automatic end_sim;
      if (fails == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   function automatic logic sel(input int w);
      return w == 0 ? vco_feedback_clock :
             w == 1 ? bus_clock : base_clock_output;
   endfunction : sel
   // Pulse width per reference period equals the skew; only no skew and a
   // half-period skew are used, where lead and lag give the same width.
   function automatic int exp_pump(input int k);
      return 8 * k;
   endfunction : exp_pump
   function automatic logic [31:0] exp_ctr(input int l, e);
      return (FNOM_100HZ * l) << e;
   endfunction : exp_ctr
   task automatic till(input int w, input logic v);
      int k;
      for (k = 0; k < 300 && sel(w) !== v; k++) begin
         @(negedge mclk);
         p++;
      end
   endtask : till
   // Syncs to a rising edge first so a partial period is never counted.
   task automatic per(input int w);
      till(w, 0); till(w, 1); p = 0; till(w, 0); till(w, 1);
   endtask : per
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : settle
   task automatic pumps(input int k);
      int n;
      @(posedge mclk) vph <= k;
      settle(40);
      cu = 0;
      cd = 0;
      for (n = 0; n < 64; n++) begin
         cu += int'(pump_up);
         cd += int'(pump_down);
         @(negedge mclk);
      end
   endtask : pumps
   task automatic wait_lock(input logic v);
      int k;
      for (k = 0; k < 900 && lock_flag !== v; k++) @(negedge mclk);
   endtask : wait_lock
   task automatic ack;
      @(posedge mclk) irq_ack <= 1;
      @(posedge mclk) irq_ack <= 0;
      settle(1);
   endtask : ack
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      end_sim;
   end
   initial begin
      {mclk, cyc, vph, fails, check_count, p} = '0;
      {pll_power_on, base_clock_select, auto_bandwidth} = '0;
      {filter_narrow_ctl, pll_irq_enable, irq_ack} = '0;
      {reference_clock, vco_output_clock} = '0;
      srst = 1; vp = 4; mult_n = 12'h002; range_l = 8'h46; range_e = 2'h0;
      void'($urandom(79981));
      repeat (3) @(posedge mclk);
      srst <= 0;
      settle(0);
      chk("irq", pll_irq, 0);
      chk("mode", filter_mode, PLLC_OFF);
      for (i = 0; i < 8; i++) begin
         @(posedge mclk);
         range_l <= i == 0 ? 8'hff : 8'($urandom);
         range_e <= 2'($urandom_range(2));
         settle(2);
         chk("center", vco_center_100hz, exp_ctr(range_l, range_e));
      end
      // Manual start-up with L zero: the loop, the pumps and the VCO select
      // stay off through the narrow and clock select writes and their waits.
      @(posedge mclk);
      pll_power_on <= 1'b1;
      range_l      <= 8'h00;
      settle(40);
      @(posedge mclk) filter_narrow_ctl <= 1'b1;
      settle(40);
      @(posedge mclk) base_clock_select <= 1'b1;
      settle(40);
      chk("loop_en", loop_enable, 0);
      chk("vco_sel", vco_selected, 0);
      chk("pump_off", {pump_up, pump_down}, 0);
      per(1);
      chk("bus_ref", p, 32);
      @(posedge mclk) range_l <= 8'($urandom_range(255, 1));
      settle(40);
      chk("vco_sel", vco_selected, 1);
      per(1);
      chk("bus_vco", p, 4 * vp);
      per(2);
      chk("base_vco", p, 2 * vp);
      for (i = 2; i < 4; i++) begin
         @(posedge mclk) mult_n <= 12'(i);
         settle(40);
         per(0);
         chk("fb_per", p, i * vp);
      end
      @(posedge mclk);
      {auto_bandwidth, pll_irq_enable} <= 2'h3;
      mult_n <= 12'h002;
      wait_lock(1);
      chk("lock", lock_flag, 1);
      chk("narrow", filter_narrow_sel, 1);
      chk("irq", pll_irq, 1);
      settle(0);
      chk("mode", filter_mode, PLLC_TRACK);
      chk("track", tracking_mode, 1);
      ack;
      chk("irq_ack", pll_irq, 0);
      @(posedge mclk) mult_n <= 12'h004;
      wait_lock(0);
      chk("narrow", filter_narrow_sel, 0);
      chk("irq", pll_irq, 1);
      // A reset in mid-run must drop a pending request as well.
      @(posedge mclk) srst <= 1'b1;
      @(posedge mclk) srst <= 1'b0;
      settle(0);
      chk("irq_rst", pll_irq, 0);
      chk("mode_rst", filter_mode, PLLC_OFF);
      ack;
      @(posedge mclk);
      mult_n <= 12'h000;
      vp <= 8;
      wait_lock(1);
      chk("lock_n0", lock_flag, 1);
      pumps(0);
      chk("pump_sum", cu + cd, exp_pump(0));
      pumps(4);
      chk("pump_sum", cu + cd, exp_pump(4));
      chk("pump_one", cu == 0 || cd == 0, 1);
      @(posedge mclk) auto_bandwidth <= 0;
      settle(3);
      ack;
      for (i = 0; i < 24; i++) begin
         @(posedge mclk) filter_narrow_ctl <= 1'($urandom);
         settle(1);
         chk("man_narrow", filter_narrow_sel, filter_narrow_ctl);
         chk("man_lock", lock_flag, 0);
         chk("man_irq", pll_irq, 0);
      end
      end_sim;
   end
endmodule : pllc_top_tb
`default_nettype wire
